/* File: hw/fmrst_pkg.sv */
// types for the mode-exit and software-reset command block
package fmrst_pkg;
  // ==========================================================
  // command mode
  typedef enum logic {
    MODE_SERIAL,
    MODE_QUAD
  } fmrst_mode_t;
  // ==========================================================
  // volatile settings lost on a software reset
  typedef struct packed {
    logic writeEnableLatch;
    logic [7:0] readParameterBits;
    logic [7:0] continuousReadBits;
    logic [2:0] wrapSettingBits;
    logic [7:0] volatileStatus;
  } fmrst_vol_t;
endpackage : fmrst_pkg

/* File: hw/fmrst_regs.svh */
// constants for the mode-exit and software-reset command block
`ifndef FMRST_REGS_SVH
`define FMRST_REGS_SVH
// ==========================================================
// opcodes
`define FMRST_OP_EXIT 8'hff
`define FMRST_OP_ENTER 8'h38
`define FMRST_OP_ARM 8'h66
`define FMRST_OP_EXEC 8'h99
// ==========================================================
// edges per complete opcode
`define FMRST_EDGES_SERIAL 8'h08
`define FMRST_EDGES_QUAD 8'h02
// ==========================================================
// register byte offsets
`define FMRST_OFS_CTRL 12'h000
`define FMRST_OFS_VSTAT 12'h004
`define FMRST_OFS_STATUS 12'h008
`define FMRST_OFS_RSTCNT 12'h00c
// ==========================================================
// field positions
`define FMRST_CTRL_QUADEN 0
`define FMRST_CTRL_WRLATCH 1
`define FMRST_CTRL_RDPAR 8
`define FMRST_CTRL_CONT 16
`define FMRST_CTRL_WRAP 24
`define FMRST_ST_QUAD 0
`define FMRST_ST_ARMED 1
`define FMRST_ST_RECOV 2
`define FMRST_ST_OPC 8
`define FMRST_ST_DUMMY 16
`define FMRST_ST_WRAPLEN 20
// ==========================================================
// reset values
`define FMRST_RST_RDPAR 8'h00
`define FMRST_RST_CONT 8'h00
`define FMRST_RST_WRAP 3'h0
`define FMRST_RST_VSTAT 8'h00
// ==========================================================
// timing
`define FMRST_CLK_PERIOD_NS 10
`define FMRST_RECOV_TIME_NS 30000
`define FMRST_RECOV_CYC ((`FMRST_RECOV_TIME_NS + `FMRST_CLK_PERIOD_NS - 1) / `FMRST_CLK_PERIOD_NS)
`endif

/* File: hw/fmrst_top.sv */
// mode-exit and two-step software reset command decoder with apb access
`timescale 1ns/100ps
`default_nettype none
`include "fmrst_regs.svh"

module fmrst_top (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic linkClk,
  input wire logic chipSelectN,
  input wire logic [3:0] linkIo,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic quadModeOut,
  output logic recoveringOut,
  output logic abortPulse
);

  // ==========================================================
  // link side: shift both interpretations, the system side picks one
  logic [7:0] serialShift_q;
  logic [7:0] serialShift_d;
  logic [7:0] quadShift_q;
  logic [7:0] quadShift_d;
  logic [7:0] edgeCnt_q;
  logic [7:0] edgeCnt_d;

  always_comb
  begin
    serialShift_d = {serialShift_q[6:0], linkIo[0]};
    quadShift_d = {quadShift_q[3:0], linkIo};
    edgeCnt_d = edgeCnt_q + 8'h01;
  end

  // link clock stands still while chip select is high, so these hold for the system side
  always_ff @(posedge linkClk or posedge reset)
  begin
    if (reset)
    begin
      serialShift_q <= 8'h00;
      quadShift_q <= 8'h00;
      edgeCnt_q <= 8'h00;
    end
    else
    begin
      serialShift_q <= serialShift_d;
      quadShift_q <= quadShift_d;
      edgeCnt_q <= edgeCnt_d;
    end
  end

  // ==========================================================
  // chip select synchroniser and frame end detect
  logic csMeta_q;
  logic csSync_q;
  logic csLast_q;
  logic frameEnd;

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      csMeta_q <= 1'b1;
      csSync_q <= 1'b1;
      csLast_q <= 1'b1;
    end
    else
    begin
      csMeta_q <= chipSelectN;
      csSync_q <= csMeta_q;
      csLast_q <= csSync_q;
    end
  end

  assign frameEnd = csSync_q & ~csLast_q;

  // ==========================================================
  // command decode and reset sequencing
  fmrst_pkg::fmrst_mode_t mode_q;
  fmrst_pkg::fmrst_mode_t mode_d;
  fmrst_pkg::fmrst_vol_t vol_q;
  fmrst_pkg::fmrst_vol_t vol_d;
  logic quadEnable_q;
  logic quadEnable_d;
  logic armed_q;
  logic armed_d;
  logic [11:0] recovCnt_q;
  logic [11:0] recovCnt_d;
  logic [7:0] lastEdge_q;
  logic [7:0] lastEdge_d;
  logic [7:0] lastOp_q;
  logic [7:0] lastOp_d;
  logic [15:0] resetCount_q;
  logic [15:0] resetCount_d;
  logic abort_q;
  logic abort_d;
  logic [7:0] frameEdges;
  logic [7:0] frameOp;
  logic fullOpcode;
  logic busWrite;

  assign frameEdges = edgeCnt_q - lastEdge_q;
  // quad-command mode moves a nibble per edge, serial mode one bit
  assign frameOp = (mode_q == fmrst_pkg::MODE_QUAD) ? quadShift_q : serialShift_q;
  assign fullOpcode = (mode_q == fmrst_pkg::MODE_QUAD) ?
                      (frameEdges == `FMRST_EDGES_QUAD) :
                      (frameEdges == `FMRST_EDGES_SERIAL);
  assign busWrite = psel & penable & pwrite & pready;

  always_comb
  begin
    mode_d = mode_q;
    vol_d = vol_q;
    quadEnable_d = quadEnable_q;
    armed_d = armed_q;
    recovCnt_d = recovCnt_q;
    lastEdge_d = lastEdge_q;
    lastOp_d = lastOp_q;
    resetCount_d = resetCount_q;
    abort_d = 1'b0;
    if (recovCnt_q != 12'h000)
    begin
      recovCnt_d = recovCnt_q - 12'h001;
    end
    // software writes stand for the rest of the instruction set
    if (busWrite && paddr == `FMRST_OFS_CTRL)
    begin
      quadEnable_d = pwdata[`FMRST_CTRL_QUADEN];
      vol_d.writeEnableLatch = pwdata[`FMRST_CTRL_WRLATCH];
      vol_d.readParameterBits = pwdata[`FMRST_CTRL_RDPAR +: 8];
      vol_d.continuousReadBits = pwdata[`FMRST_CTRL_CONT +: 8];
      vol_d.wrapSettingBits = pwdata[`FMRST_CTRL_WRAP +: 3];
    end
    if (busWrite && paddr == `FMRST_OFS_VSTAT)
    begin
      vol_d.volatileStatus = pwdata[7:0];
    end
    if (frameEnd)
    begin
      // the edge count is taken after every frame, refused ones too
      lastEdge_d = edgeCnt_q;
      // frames during recovery are dropped whole and leave the arm state alone
      if (recovCnt_q == 12'h000 && frameEdges != 8'h00)
      begin
        lastOp_d = frameOp;
        if (fullOpcode && frameOp == `FMRST_OP_ARM)
        begin
          armed_d = 1'b1;
        end
        else if (fullOpcode && frameOp == `FMRST_OP_EXEC && armed_q)
        begin
          // software reset beats a bus write to the volatile settings in the same cycle
          armed_d = 1'b0;
          mode_d = fmrst_pkg::MODE_SERIAL;
          vol_d.writeEnableLatch = 1'b0;
          vol_d.readParameterBits = `FMRST_RST_RDPAR;
          vol_d.continuousReadBits = `FMRST_RST_CONT;
          vol_d.wrapSettingBits = `FMRST_RST_WRAP;
          vol_d.volatileStatus = `FMRST_RST_VSTAT;
          abort_d = 1'b1;
          recovCnt_d = 12'(`FMRST_RECOV_CYC);
          resetCount_d = resetCount_q + 16'h0001;
        end
        else
        begin
          armed_d = 1'b0;
          if (fullOpcode && frameOp == `FMRST_OP_EXIT && mode_q == fmrst_pkg::MODE_QUAD)
          begin
            // settings in vol_d are left as they stand
            mode_d = fmrst_pkg::MODE_SERIAL;
          end
          else if (fullOpcode && frameOp == `FMRST_OP_ENTER && quadEnable_q)
          begin
            mode_d = fmrst_pkg::MODE_QUAD;
          end
        end
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      mode_q <= fmrst_pkg::MODE_SERIAL;
      vol_q <= '{1'b0, `FMRST_RST_RDPAR, `FMRST_RST_CONT, `FMRST_RST_WRAP,
                 `FMRST_RST_VSTAT};
      quadEnable_q <= 1'b0;
      armed_q <= 1'b0;
      recovCnt_q <= 12'h000;
      lastEdge_q <= 8'h00;
      lastOp_q <= 8'h00;
      resetCount_q <= 16'h0000;
      abort_q <= 1'b0;
    end
    else
    begin
      mode_q <= mode_d;
      vol_q <= vol_d;
      quadEnable_q <= quadEnable_d;
      armed_q <= armed_d;
      recovCnt_q <= recovCnt_d;
      lastEdge_q <= lastEdge_d;
      lastOp_q <= lastOp_d;
      resetCount_q <= resetCount_d;
      abort_q <= abort_d;
    end
  end

  // ==========================================================
  // decoded read settings
  logic [3:0] dummyClocks;
  logic [6:0] wrapBytes;

  always_comb
  begin
    dummyClocks = {1'b0, vol_q.readParameterBits[5:4], 1'b0} + 4'h2;
    wrapBytes = 7'h08 << vol_q.readParameterBits[1:0];
  end

  // ==========================================================
  // apb slave, one wait state on every access
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic pready_q;
  logic pready_d;
  logic pslverr_q;
  logic pslverr_d;
  logic mapped;

  always_comb
  begin
    mapped = (paddr == `FMRST_OFS_CTRL) || (paddr == `FMRST_OFS_VSTAT) ||
             (paddr == `FMRST_OFS_STATUS) || (paddr == `FMRST_OFS_RSTCNT);
    pready_d = psel & penable & ~pready_q;
    pslverr_d = pready_d & ~mapped;
    prdata_d = 32'h0000_0000;
    if (pready_d && !pwrite)
    begin
      case (paddr)
        `FMRST_OFS_CTRL:
        begin
          prdata_d[`FMRST_CTRL_QUADEN] = quadEnable_q;
          prdata_d[`FMRST_CTRL_WRLATCH] = vol_q.writeEnableLatch;
          prdata_d[`FMRST_CTRL_RDPAR +: 8] = vol_q.readParameterBits;
          prdata_d[`FMRST_CTRL_CONT +: 8] = vol_q.continuousReadBits;
          prdata_d[`FMRST_CTRL_WRAP +: 3] = vol_q.wrapSettingBits;
        end
        `FMRST_OFS_VSTAT:
        begin
          prdata_d[7:0] = vol_q.volatileStatus;
        end
        `FMRST_OFS_STATUS:
        begin
          prdata_d[`FMRST_ST_QUAD] = (mode_q == fmrst_pkg::MODE_QUAD);
          prdata_d[`FMRST_ST_ARMED] = armed_q;
          prdata_d[`FMRST_ST_RECOV] = (recovCnt_q != 12'h000);
          prdata_d[`FMRST_ST_OPC +: 8] = lastOp_q;
          prdata_d[`FMRST_ST_DUMMY +: 4] = dummyClocks;
          prdata_d[`FMRST_ST_WRAPLEN +: 7] = wrapBytes;
        end
        `FMRST_OFS_RSTCNT:
        begin
          prdata_d[15:0] = resetCount_q;
        end
        default:
        begin
          prdata_d = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
    else
    begin
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // ==========================================================
  // outputs, all from flip-flops
  logic quadOut_q;
  logic recovOut_q;

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      quadOut_q <= 1'b0;
      recovOut_q <= 1'b0;
    end
    else
    begin
      quadOut_q <= (mode_d == fmrst_pkg::MODE_QUAD);
      recovOut_q <= (recovCnt_d != 12'h000);
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign quadModeOut = quadOut_q;
  assign recoveringOut = recovOut_q;
  assign abortPulse = abort_q;

endmodule : fmrst_top

`default_nettype wire

/* File: testbench/fmrst_host_model.sv */
// host flash controller model that frames opcodes on the link
`timescale 1ns/100ps
`default_nettype none
module fmrst_host_model (
  output logic linkClk,
  output logic chipSelectN,
  output logic [3:0] linkIo
);
  // ==========================================================
  // idle link: clock parked low; no write instruction is ever framed
  initial
  begin
    linkClk = 1'b0;
    chipSelectN = 1'b1;
    linkIo = 4'h5;
  end
  // ==========================================================
  // one frame, msb first, 80 ns link period
  task automatic send_frame(input logic [7:0] op, input int edges, input logic quad);
    logic [7:0] sr;
    sr = op;
    #13 chipSelectN = 1'b0;
    for (int i = 0; i < edges; i++)
    begin
      linkIo = quad ? sr[7:4] : {~linkIo[3:1], sr[7]};
      sr = quad ? {sr[3:0], 4'h0} : {sr[6:0], 1'b0};
      #40 linkClk = 1'b1;
      #40 linkClk = 1'b0;
    end
    #40 chipSelectN = 1'b1;
    // released lines flip so a stale value is never mistaken for data
    linkIo = ~linkIo;
    #60;
  endtask : send_frame
endmodule : fmrst_host_model
`default_nettype wire

/* File: testbench/fmrst_top_asserts.sv */
// assertion checker for the mode-exit and reset decoder
`timescale 1ns/100ps
`default_nettype none
`include "fmrst_regs.svh"
module fmrst_top_asserts (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic linkClk,
  input wire logic chipSelectN,
  input wire logic [3:0] linkIo,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic quadModeOut,
  input wire logic recoveringOut,
  input wire logic abortPulse
);
  // ==========================================================
  // recovery length: counted, since 3000 cycles is too long to unroll
  logic [12:0] recCnt_q;
  logic [12:0] recCnt_d;
  always_comb recCnt_d = (reset || !recoveringOut) ? 13'h0 : recCnt_q + 13'h1;
  always_ff @(posedge clk_sys) recCnt_q <= recCnt_d;
  // ==========================================================
  // properties
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  a_ready_wait: assert property (psel && $rose(penable) |=> pready)
    else $error("ready late");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("data outside ready");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_abort_recov: assert property (abortPulse |=> !abortPulse && recoveringOut)
    else $error("abort without recovery");
  a_abort_serial: assert property (abortPulse |=> !quadModeOut)
    else $error("reset kept quad mode");
  a_recov_len: assert property ($fell(recoveringOut) |-> recCnt_q == 13'(`FMRST_RECOV_CYC))
    else $error("recovery length wrong");
  a_recov_serial: assert property (recoveringOut && $past(recoveringOut) |-> !quadModeOut)
    else $error("quad mode during recovery");
  a_mode_frame: assert property ($changed(quadModeOut) |-> chipSelectN)
    else $error("mode changed inside frame");
  c_abort: cover property (abortPulse);
  c_quad_exit: cover property ($fell(quadModeOut));
  c_bad_addr: cover property (pslverr);
endmodule : fmrst_top_asserts
bind fmrst_top fmrst_top_asserts i_chk (.clk_sys(clk_sys), .reset(reset), .linkClk(linkClk),
  .chipSelectN(chipSelectN), .linkIo(linkIo), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .quadModeOut(quadModeOut), .recoveringOut(recoveringOut), .abortPulse(abortPulse));
`default_nettype wire

/* File: testbench/tb.sv */
// self-checking bench for the mode-exit and reset decoder
`timescale 1ns/100ps
`default_nettype none
`include "fmrst_regs.svh"
module tb;
  // ==========================================================
  // signals
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [3:0] linkIo;
  logic pready, pslverr, quadModeOut, recoveringOut, abortPulse, linkClk, chipSelectN;
  int failures = 0, cmp_count = 0, cycles = 0, aborts = 0;
  initial
  begin
    forever #5 clk_sys = ~clk_sys;
  end
  fmrst_host_model i_host (.linkClk(linkClk), .chipSelectN(chipSelectN), .linkIo(linkIo));
  fmrst_top i_dut (.clk_sys(clk_sys), .reset(reset), .linkClk(linkClk),
    .chipSelectN(chipSelectN), .linkIo(linkIo), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .quadModeOut(quadModeOut), .recoveringOut(recoveringOut),
    .abortPulse(abortPulse));
  always @(posedge clk_sys)
  begin
    cycles = cycles + 1;
    if (abortPulse === 1'b1) aborts = aborts + 1;
    if (cycles == 20000)
    begin
      failures = failures + 1;
      finish_test();
    end
  end
  // ==========================================================
  // shared tasks
  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : finish_test
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
    output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge clk_sys);
      n++;
    end
    if (n == 20) failures++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    check(r & m, x);
  endtask : rd_chk
  task automatic frame(input logic [7:0] op, input int edges, input logic quad);
    i_host.send_frame(op, edges, quad);
    repeat (12) @(posedge clk_sys);
  endtask : frame
  // ==========================================================
  // scenarios
  task automatic t_regs();
    logic [31:0] r;
    logic e;
    rd_chk(`FMRST_OFS_CTRL, 32'hffffffff, 32'h0);
    rd_chk(`FMRST_OFS_STATUS, 32'h07ff0007, 32'h00820000);
    apb(1'b1, `FMRST_OFS_VSTAT, 32'ha5, r, e);
    apb(1'b1, 12'h010, 32'h1234, r, e);
    check({31'h0, e}, 32'h1);
    apb(1'b0, 12'h010, 32'h0, r, e);
    check({r[30:0], e}, 32'h1);
    $display("test regs done");
  endtask : t_regs
  task automatic t_mode();
    logic [31:0] r;
    logic e;
    frame(`FMRST_OP_ENTER, 8, 1'b0);
    check({31'h0, quadModeOut}, 32'h0);
    apb(1'b1, `FMRST_OFS_CTRL, 32'h053c2103, r, e);
    frame(`FMRST_OP_ENTER, 8, 1'b0);
    check({31'h0, quadModeOut}, 32'h1);
    frame(`FMRST_OP_EXIT, 2, 1'b1);
    check({31'h0, quadModeOut}, 32'h0);
    rd_chk(`FMRST_OFS_CTRL, 32'hffffffff, 32'h053c2103);
    rd_chk(`FMRST_OFS_STATUS, 32'h07ff0001, 32'h01060000);
    $display("test mode done");
  endtask : t_mode
  task automatic t_arm();
    frame(`FMRST_OP_ARM, 8, 1'b0);
    rd_chk(`FMRST_OFS_STATUS, 32'hff02, 32'h6602);
    frame(8'h05, 8, 1'b0);
    rd_chk(`FMRST_OFS_STATUS, 32'hff02, 32'h0500);
    frame(`FMRST_OP_EXEC, 8, 1'b0);
    frame(`FMRST_OP_ARM, 7, 1'b0);
    frame(`FMRST_OP_EXEC, 8, 1'b0);
    check(32'(aborts), 32'h0);
    $display("test arm done");
  endtask : t_arm
  task automatic t_reset();
    int n;
    frame(`FMRST_OP_ENTER, 8, 1'b0);
    rd_chk(`FMRST_OFS_STATUS, 32'h1, 32'h1);
    frame(`FMRST_OP_ARM, 2, 1'b1);
    frame(`FMRST_OP_EXEC, 2, 1'b1);
    check({29'h0, recoveringOut, quadModeOut, 1'b0}, 32'h4);
    frame(`FMRST_OP_ARM, 8, 1'b0);
    frame(`FMRST_OP_EXEC, 8, 1'b0);
    check(32'(aborts), 32'h1);
    rd_chk(`FMRST_OFS_CTRL, 32'hffffffff, 32'h1);
    rd_chk(`FMRST_OFS_VSTAT, 32'hff, 32'h0);
    rd_chk(`FMRST_OFS_STATUS, 32'h07ff0000, 32'h00820000);
    n = 0;
    while (recoveringOut !== 1'b0 && n < 4000)
    begin
      @(posedge clk_sys);
      n++;
    end
    frame(`FMRST_OP_ARM, 8, 1'b0);
    frame(`FMRST_OP_EXEC, 8, 1'b0);
    rd_chk(`FMRST_OFS_RSTCNT, 32'hffff, 32'h2);
    $display("test reset done");
  endtask : t_reset
  initial
  begin
    repeat (8) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (4) @(posedge clk_sys);
    t_regs();
    t_mode();
    t_arm();
    t_reset();
    finish_test();
  end
endmodule : tb
`default_nettype wire
